// ### rtl/sfwe_engine.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] Normal mode: rising frame sync starts the bit counter and shifting.
// [RULE2] Counter at word length: clear it, load shift register into data register.
// [RULE3] Normal mode: bit clocks after word end are ignored.
// [RULE4] Normal mode: next word starts only on next rising frame sync.
// [RULE5] Network mode: rising frame sync also starts the bit counter.
// [RULE6] Network mode: flag marks the word that came with a frame sync.
// [RULE7] Network mode: keep counting, shift next word without frame sync.
// [RULE8] Network mode: packet complete only at next rising frame sync.
// [RULE9] Settings select mode and word length.
module sfwe_engine
   import sfwe_pkg::*;
(
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic reset, // Synchronous, active high
   input wire logic network_mode, // 1 = network, 0 = normal
   input wire logic [SFWE_LEN_W-1:0] word_length, // Bits per word, 1..24
   input wire logic serial_clk_in, // External bit clock pin
   input wire logic frame_sync_in, // External frame sync pin
   input wire logic serial_data_in, // Serial receive data pin
   input wire logic [SFWE_WORD_MAX-1:0] tx_word, // Word to send
   output logic serial_data_out, // Serial transmit data
   output logic serial_data_oe, // High while driving data pin
   output logic [SFWE_WORD_MAX-1:0] rx_word, // Data register
   output logic rx_word_valid, // Pulse: new word loaded
   output logic word_had_frame_sync_flag, // Network mode: word came with frame sync
   output logic packet_done, // Pulse: network packet complete
   output logic tx_word_taken // Pulse: tx_word sampled
);
   // Receive assembly, transmit shift and data register
   sfwe_state_t state_reg, state_next;
   logic [SFWE_LEN_W-1:0] count_reg, count_next;
   logic [SFWE_WORD_MAX-1:0] shift_reg, shift_next;
   logic [SFWE_WORD_MAX-1:0] txsh_reg, txsh_next;
   logic [SFWE_WORD_MAX-1:0] rx_word_reg, rx_word_next;
   logic valid_reg, valid_next;
   logic fsflag_reg, fsflag_next;
   logic first_reg, first_next;
   logic done_reg, done_next;
   logic taken_reg, taken_next;
   logic sdo_reg, sdo_next;
   logic oe_reg, oe_next;
   logic [SFWE_LEN_W-1:0] len_eff;
   // Edge pulses and levels from the pin synchronisers
   logic sck_rise, sck_fall, fs_rise, sdi_level;

   // Out of range lengths are clamped so the counter always terminates
   function automatic logic [SFWE_LEN_W-1:0] clamp_len(input logic [SFWE_LEN_W-1:0] l);
      if (l < SFWE_LEN_MIN) begin
         clamp_len = SFWE_LEN_MIN;
      end else if (l > SFWE_LEN_W'(SFWE_WORD_MAX)) begin
         clamp_len = SFWE_LEN_W'(SFWE_WORD_MAX);
      end else begin
         clamp_len = l;
      end
   endfunction

   // Length is read live; change it only while the port is idle
   assign len_eff = clamp_len(word_length); // [RULE9]

   // Every pin passes two flops, so edges lag the pins by about two cycles
   // Bit clock must stay high and low for at least three system clocks
   sfwe_sync_edge u_sck (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(serial_clk_in),
      .level_out(),
      .rise_pulse(sck_rise),
      .fall_pulse(sck_fall)
   );

   sfwe_sync_edge u_fs (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(frame_sync_in),
      .level_out(),
      .rise_pulse(fs_rise),
      .fall_pulse()
   );

   sfwe_sync_edge u_sdi (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(serial_data_in),
      .level_out(sdi_level),
      .rise_pulse(),
      .fall_pulse()
   );

   // Word engine: data sampled on bit clock rise, driven on fall
   always_comb begin
      // Pulses default low; everything else holds
      state_next = state_reg;
      count_next = count_reg;
      shift_next = shift_reg;
      txsh_next = txsh_reg;
      rx_word_next = rx_word_reg;
      valid_next = 1'h0;
      fsflag_next = fsflag_reg;
      first_next = first_reg;
      done_next = 1'h0;
      taken_next = 1'h0;
      sdo_next = sdo_reg;
      oe_next = oe_reg;
      // One-hot states; an illegal code falls back to idle
      case (state_reg)
         SFWE_IDLE: begin
            oe_next = 1'h0;
            if (fs_rise) begin
               // Start counting from zero on frame sync
               state_next = SFWE_SHIFT; // [RULE1] [RULE5]
               count_next = '0;
               // Empty register so short words read back zero extended
               shift_next = SFWE_DATA_RESET;
               first_next = 1'h1;
               txsh_next = tx_word;
               taken_next = 1'h1;
               // First bit must stand before the first bit clock rise
               sdo_next = tx_word[SFWE_WORD_MAX-1];
               oe_next = 1'h1;
            end
         end
         SFWE_SHIFT: begin
            if (fs_rise && network_mode && !first_reg) begin
               // Fresh frame sync closes the packet and restarts
               // A partly shifted word is dropped, not delivered
               done_next = 1'h1; // [RULE8]
               count_next = '0;
               shift_next = SFWE_DATA_RESET;
               first_next = 1'h1;
               txsh_next = tx_word;
               taken_next = 1'h1;
               // Output enable stays high across the restart
               sdo_next = tx_word[SFWE_WORD_MAX-1];
            end else if (sck_rise) begin
               shift_next = {shift_reg[SFWE_WORD_MAX-2:0], sdi_level};
               if (count_reg + 5'h01 == len_eff) begin
                  count_next = '0; // [RULE2]
                  rx_word_next = {shift_reg[SFWE_WORD_MAX-2:0], sdi_level}; // [RULE2]
                  // Next word assembles from an empty register
                  shift_next = SFWE_DATA_RESET;
                  valid_next = 1'h1;
                  // In network mode only the first word after a frame sync is marked; normal-mode words never are
                  fsflag_next = network_mode & first_reg; // [RULE6]
                  first_next = 1'h0;
                  if (network_mode) begin
                     // Chained word reuses whatever tx_word holds now
                     txsh_next = tx_word; // [RULE7]
                     taken_next = 1'h1;
                  end else begin
                     state_next = SFWE_WAIT; // [RULE3]
                  end
               end else begin
                  // Advance the transmit word by one bit
                  count_next = count_reg + 5'h01;
                  txsh_next = {txsh_reg[SFWE_WORD_MAX-2:0], 1'h0};
               end
            end else if (sck_fall) begin
               // Transmit word is left aligned: MSB first whatever the length
               sdo_next = txsh_reg[SFWE_WORD_MAX-1];
            end
         end
         SFWE_WAIT: begin
            // Pin is released between words
            oe_next = 1'h0;
            // Bit clocks are dropped here until the next frame sync
            if (fs_rise) begin
               state_next = SFWE_SHIFT; // [RULE4]
               count_next = '0;
               shift_next = SFWE_DATA_RESET;
               first_next = 1'h1;
               txsh_next = tx_word;
               taken_next = 1'h1;
               sdo_next = tx_word[SFWE_WORD_MAX-1];
               oe_next = 1'h1;
            end
         end
         default: begin
            state_next = SFWE_IDLE;
         end
      endcase
   end

   // State registers, synchronous reset only
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= SFWE_IDLE;
         count_reg <= '0;
         shift_reg <= SFWE_DATA_RESET;
         txsh_reg <= SFWE_DATA_RESET;
         rx_word_reg <= SFWE_DATA_RESET;
         valid_reg <= 1'h0;
         fsflag_reg <= 1'h0;
         first_reg <= 1'h0;
         done_reg <= 1'h0;
         taken_reg <= 1'h0;
         sdo_reg <= 1'h0;
         oe_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         shift_reg <= shift_next;
         txsh_reg <= txsh_next;
         rx_word_reg <= rx_word_next;
         valid_reg <= valid_next;
         fsflag_reg <= fsflag_next;
         first_reg <= first_next;
         done_reg <= done_next;
         taken_reg <= taken_next;
         sdo_reg <= sdo_next;
         oe_reg <= oe_next;
      end
   end

   // Outputs straight from flops, so no glitches reach the pins
   assign rx_word = rx_word_reg;
   assign rx_word_valid = valid_reg;
   assign word_had_frame_sync_flag = fsflag_reg;
   assign packet_done = done_reg;
   assign tx_word_taken = taken_reg;
   assign serial_data_out = sdo_reg;
   assign serial_data_oe = oe_reg;
endmodule
`default_nettype wire

// ### rtl/sfwe_pkg.sv
package sfwe_pkg;
   // Serial word geometry
   localparam int SFWE_WORD_MAX = 24;
   localparam int SFWE_LEN_W = 5;
   localparam logic [SFWE_LEN_W-1:0] SFWE_LEN_RESET = 5'h18;
   localparam logic [SFWE_LEN_W-1:0] SFWE_LEN_MIN = 5'h01;
   localparam logic SFWE_MODE_NORMAL = 1'h0;
   localparam logic SFWE_MODE_NETWORK = 1'h1;
   localparam logic [SFWE_WORD_MAX-1:0] SFWE_DATA_RESET = 24'h000000;

   // Word engine states
   typedef enum logic [2:0] {
      SFWE_IDLE = 3'b001,
      SFWE_SHIFT = 3'b010,
      SFWE_WAIT = 3'b100
   } sfwe_state_t;
endpackage

// ### rtl/sfwe_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module sfwe_sync_edge (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Synchronous reset
   input wire logic async_in, // Pin from outside domain
   output logic level_out, // Synchronised level
   output logic rise_pulse, // One-cycle rising edge
   output logic fall_pulse // One-cycle falling edge
);
   logic meta_reg, meta_next;
   logic sync_reg, sync_next;
   logic last_reg, last_next;

   // Two flops, then a history flop for edge detection
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
      last_next = sync_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_reg <= 1'h0;
         sync_reg <= 1'h0;
         last_reg <= 1'h0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   assign level_out = sync_reg;
   assign rise_pulse = sync_reg & ~last_reg;
   assign fall_pulse = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// ### bench/sfwe_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sfwe_asserts
   import sfwe_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic network_mode,
   input wire logic frame_sync_in,
   input wire logic serial_data_oe,
   input wire logic [SFWE_WORD_MAX-1:0] rx_word,
   input wire logic rx_word_valid,
   input wire logic word_had_frame_sync_flag,
   input wire logic packet_done,
   input wire logic tx_word_taken
);
   logic fs_d_reg;
   logic seen_reg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // A frame sync must come between two normal-mode words
   always_ff @(posedge clk_sys) begin
      fs_d_reg <= frame_sync_in;
      if (reset || rx_word_valid) seen_reg <= 1'h0;
      else if (frame_sync_in && !fs_d_reg) seen_reg <= 1'h1;
   end
   AST_VALID_PULSE: assert property (rx_word_valid |=> !rx_word_valid) else $error("valid too long");
   AST_RX_HOLD: assert property (!rx_word_valid |-> $stable(rx_word)) else $error("rx moved");
   AST_FLAG_HOLD: assert property (!rx_word_valid |-> $stable(word_had_frame_sync_flag)) else $error("flag moved");
   AST_FLAG_NORM: assert property (rx_word_valid && !network_mode |-> !word_had_frame_sync_flag) else $error("flag");
   AST_DONE_NET: assert property (packet_done |-> network_mode) else $error("done in normal");
   AST_NORM_START: assert property (tx_word_taken && !network_mode |-> $past(frame_sync_in, 3)) else $error("start");
   AST_NORM_IGNORE: assert property (rx_word_valid && !network_mode |-> seen_reg) else $error("no fs");
   AST_NORM_OE: assert property (rx_word_valid && !network_mode |-> ##[0:8] !serial_data_oe) else $error("oe");
   AST_NET_GOES_ON: assert property (rx_word_valid && network_mode |-> serial_data_oe) else $error("stop");
endmodule
bind sfwe_engine sfwe_asserts u_chk(.clk_sys(clk_sys), .reset(reset), .network_mode(network_mode),
   .frame_sync_in(frame_sync_in), .serial_data_oe(serial_data_oe), .rx_word(rx_word),
   .rx_word_valid(rx_word_valid), .word_had_frame_sync_flag(word_had_frame_sync_flag),
   .packet_done(packet_done), .tx_word_taken(tx_word_taken));
`default_nettype wire

// ### bench/sfwe_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module sfwe_far_end (
   input wire logic sdo, // Data from device
   output var logic sck, // Bit clock
   output var logic fs, // Frame sync
   output var logic sdi // Data to device
);
   logic [23:0] dev_word; // Bits taken from the device, last in bit 0
   initial begin
      sck = 1'h0;
      fs = 1'h0;
      sdi = 1'h0;
      dev_word = 24'h000000;
   end
   // One word, MSB first; clock stands still between calls
   task automatic send(input logic [23:0] w, input int n, input logic with_fs);
      // Gap keeps the released data apart from the next word's first bit
      #40;
      dev_word = 24'h000000;
      for (int i = 0; i < n; i++) begin
         sdi = w[n-1-i];
         if (i == 0 && with_fs) fs = 1'h1;
         #40 sck = 1'h1;
         dev_word = {dev_word[22:0], sdo};
         #40 sck = 1'h0;
         fs = 1'h0;
      end
      sdi = ~sdi; // Released: never the last value
   endtask
endmodule
`default_nettype wire

// ### bench/tb_sfwe_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sfwe_engine;
   import sfwe_pkg::*;
   logic clk_sys = 1'h0;
   logic reset, network_mode, sck, fs, sdi, sdo, oe, valid, flag, done, taken;
   logic [SFWE_LEN_W-1:0] word_length;
   logic [23:0] tx_val = 24'h5a5a5a;
   logic [23:0] rx_word, got[$];
   logic gf[$];
   int fail_count = 0, num_checks = 0, cyc = 0, ndone = 0, ntaken = 0;
   always #5 clk_sys = ~clk_sys;
   sfwe_engine dut(.clk_sys(clk_sys), .reset(reset), .network_mode(network_mode), .word_length(word_length),
      .serial_clk_in(sck), .frame_sync_in(fs), .serial_data_in(sdi), .tx_word(tx_val),
      .serial_data_out(sdo), .serial_data_oe(oe), .rx_word(rx_word), .rx_word_valid(valid),
      .word_had_frame_sync_flag(flag), .packet_done(done), .tx_word_taken(taken));
   sfwe_far_end u_far(.sdo(sdo), .sck(sck), .fs(fs), .sdi(sdi));
   // Log every word at the falling edge, where outputs have settled
   always @(negedge clk_sys) begin
      cyc++;
      if (valid === 1'h1) begin
         got.push_back(rx_word);
         gf.push_back(flag);
      end
      if (done === 1'h1) ndone++;
      if (taken === 1'h1) ntaken++;
      // Ceiling far above the roughly 650 cycles the scenarios need
      if (cyc == 20000) begin
         fail_count++;
         close_out;
      end
   end
   task check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task close_out;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Mode and length only change under reset, so idle
   task rst(input logic m, input logic [SFWE_LEN_W-1:0] len);
      reset = 1'h1;
      network_mode = m;
      word_length = len;
      repeat (3) @(negedge clk_sys);
      reset = 1'h0;
      got.delete();
      gf.delete();
      ndone = 0;
      ntaken = 0;
      @(negedge clk_sys);
   endtask
   task settle;
      repeat (12) @(negedge clk_sys);
   endtask
   task t_normal;
      rst(1'h0, 5'h08);
      u_far.send(24'h0000a5, 8, 1'h1);
      settle;
      check("rx0", got[0], 24'h0000a5);
      check("flag0", 24'(gf[0]), 24'h000000);
      check("tx0", u_far.dev_word, tx_val >> (SFWE_WORD_MAX - 8));
      check("oe_wait", 24'(oe), 24'h000000);
      u_far.send(24'h0000ff, 5, 1'h0);
      settle;
      check("count", 24'(got.size()), 24'h000001);
      check("taken", 24'(ntaken), 24'h000001);
      u_far.send(24'h00003c, 8, 1'h1);
      settle;
      check("rx1", got[1], 24'h00003c);
   endtask
   task t_network;
      rst(1'h1, 5'h05);
      u_far.send(24'h000015, 5, 1'h1);
      check("txw0", u_far.dev_word, tx_val >> (SFWE_WORD_MAX - 5));
      u_far.send(24'h00000a, 5, 1'h0);
      settle;
      check("txw1", u_far.dev_word, tx_val >> (SFWE_WORD_MAX - 5));
      check("oe_net", 24'(oe), 24'h000001);
      check("done0", 24'(ndone), 24'h000000);
      u_far.send(24'h000013, 5, 1'h1);
      settle;
      check("w0", got[0], 24'h000015);
      check("f0", 24'(gf[0]), 24'h000001);
      check("w1", got[1], 24'h00000a);
      check("f1", 24'(gf[1]), 24'h000000);
      check("w2", got[2], 24'h000013);
      check("f2", 24'(gf[2]), 24'h000001);
      check("done1", 24'(ndone), 24'h000001);
   endtask
   task t_len;
      rst(1'h0, SFWE_LEN_RESET);
      u_far.send(24'hc3a51e, SFWE_WORD_MAX, 1'h1);
      settle;
      check("max", got[0], 24'hc3a51e);
      check("txmax", u_far.dev_word, tx_val);
      rst(1'h0, SFWE_LEN_MIN);
      u_far.send(24'h000001, 1, 1'h1);
      settle;
      check("min", got[0], 24'h000001);
      // Zero length is out of range and must act as the shortest word
      rst(1'h0, 5'h00);
      u_far.send(24'h000001, 1, 1'h1);
      settle;
      check("zero", got[0], 24'h000001);
   endtask
   initial begin
      t_normal;
      t_network;
      t_len;
      close_out;
   end
endmodule
`default_nettype wire
